/* File: rtl/prs_pkg.sv */
// shared constants and carriers for the port read-back self-test block
package prs_pkg;

  // register byte offsets on the wishbone slave
  localparam logic [7:0] OFS_DATA   = 8'h00;
  localparam logic [7:0] OFS_DIR    = 8'h04;
  localparam logic [7:0] OFS_FSEL   = 8'h08;
  localparam logic [7:0] OFS_UNLOCK = 8'h0C;
  localparam logic [7:0] OFS_WAKE   = 8'h10;
  localparam logic [7:0] OFS_CHAN   = 8'h14;
  localparam logic [7:0] OFS_BITOP  = 8'h18;
  localparam logic [7:0] OFS_STAT   = 8'h1C;
  localparam logic [7:0] OFS_MASK   = 8'h20;
  localparam logic [7:0] OFS_RSTPIN = 8'h24;

  // reset values
  localparam logic [7:0]  RST_DATA   = 8'hFF;
  localparam logic [7:0]  RST_DIR    = 8'hFF;
  localparam logic [15:0] RST_FSEL   = 16'h0000;
  localparam logic [7:0]  RST_UNLOCK = 8'h00;
  localparam logic [7:0]  RST_ZERO8  = 8'h00;
  localparam logic [2:0]  RST_CHAN   = 3'h0;
  localparam logic [2:0]  RST_STAT   = 3'h0;

  // key that turns read-back mode on (binary 11001010)
  localparam logic [7:0] UNLOCK_KEY = 8'hCA;

  // bit-operation command fields
  localparam int BITOP_IDX_LSB = 0;
  localparam int BITOP_SET_POS = 3;
  localparam int BITOP_DIR_POS = 4;

  // status and mask bit positions
  localparam int ST_WAKE  = 0;
  localparam int ST_MODE  = 1;
  localparam int ST_BITOP = 2;

  // per-pin function selection codes
  typedef enum logic [1:0] {
    PRS_FN_GPIO   = 2'h0,
    PRS_FN_OUTFN  = 2'h1,
    PRS_FN_SERIAL = 2'h2,
    PRS_FN_ANALOG = 2'h3
  } prs_fn_e;

  // configuration and levels of one pin
  typedef struct packed {
    prs_fn_e fsel;
    logic    dir;
    logic    latch;
    logic    pin;
    logic    rst_pin;
  } prs_pin_cfg_s;

  // wishbone request as seen by the slave
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } prs_wb_req_s;

endpackage : prs_pkg

/* File: rtl/prs_pin_cell.sv */
// read-back value and analog switch of a single port pin
`timescale 1ns/10ps
module prs_pin_cell (
  input  wire prs_pkg::prs_pin_cfg_s cfg_i,
  input  wire logic                  mode_i,
  input  wire logic                  chan_hit_i,
  output logic                       rd_bit_o,
  output logic                       ana_close_o
);

  // value returned by a port read for this pin
  always_comb begin
    if (mode_i) begin
      rd_bit_o = cfg_i.pin;
    end else if (cfg_i.rst_pin) begin
      rd_bit_o = 1'b0;
    end else begin
      case (cfg_i.fsel)
        prs_pkg::PRS_FN_GPIO:   rd_bit_o = cfg_i.dir ? cfg_i.pin
                                                     : cfg_i.latch;
        prs_pkg::PRS_FN_OUTFN:  rd_bit_o = cfg_i.dir ? 1'b0
                                                     : cfg_i.latch;
        prs_pkg::PRS_FN_SERIAL: rd_bit_o = cfg_i.dir ? cfg_i.pin
                                                     : cfg_i.latch;
        default:                rd_bit_o = 1'b0;
      endcase
    end
  end

  // forced path lets the pin's own digital output be converted
  always_comb begin
    ana_close_o = (cfg_i.fsel == prs_pkg::PRS_FN_ANALOG)
                | (mode_i & chan_hit_i);
  end

endmodule : prs_pin_cell

/* File: rtl/prs_port_readback.sv */
// port a read-back, self-test analog path, bit ops and wake-up
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
module prs_port_readback (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [7:0]  pin_i,
  output logic      [7:0]  pin_o,
  output logic      [7:0]  pin_oe_o,
  output logic      [7:0]  ana_sw_o,
  output logic             readback_mode_active_o,
  input  wire logic        sleep_i,
  output logic             wake_o,
  output logic             irq_o
);

  typedef enum logic [1:0] {
    PRS_IDLE,
    PRS_READ,
    PRS_WRITE
  } prs_state_e;

  // bus request carrier and per-pin configuration
  prs_pkg::prs_wb_req_s req;
  prs_pkg::prs_pin_cfg_s [7:0] cfg;

  // bus sequencer state
  prs_state_e  state;
  prs_state_e  next_state;

  // software-visible port registers
  logic [7:0]  port_data_register;
  logic [7:0]  next_port_data_register;
  logic [7:0]  port_direction_control;
  logic [7:0]  next_port_direction_control;
  logic [15:0] fsel;
  logic [15:0] next_fsel;
  logic [7:0]  read_port_unlock;
  logic [7:0]  next_read_port_unlock;
  logic [7:0]  wake_en;
  logic [7:0]  next_wake_en;
  logic [2:0]  adc_chan;
  logic [2:0]  next_adc_chan;
  logic [7:0]  rst_pin_mask;
  logic [7:0]  next_rst_pin_mask;

  // sticky status and interrupt mask
  logic [2:0]  status;
  logic [2:0]  next_status;
  logic [2:0]  irq_mask;
  logic [2:0]  next_irq_mask;

  // bit-operation command and operand
  logic [4:0]  bitop_cmd;
  logic [4:0]  next_bitop_cmd;
  logic [7:0]  bitop_opnd;
  logic [7:0]  next_bitop_opnd;

  // previous pin levels for edge detect
  logic [7:0]  pin_q;

  // next values of the registered outputs
  logic [31:0] next_wb_dat;
  logic        next_wb_ack;
  logic [7:0]  next_pin_oe;
  logic [7:0]  next_ana_sw;
  logic        next_mode;
  logic        next_wake;
  logic        next_irq;

  // combinational helpers
  logic [7:0]  port_rd;
  logic [7:0]  ana_close;
  logic [7:0]  fall;
  logic        acc;
  logic        wr;
  logic        rd;
  logic [2:0]  ev;
  logic [7:0]  bit_mask;
  logic        bitop_done;

  // bundle the bus request so decode reads one carrier
  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                 adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

  // per-pin read multiplexer and analog switch
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      assign cfg[g] = '{fsel:    prs_pkg::prs_fn_e'(fsel[2*g +: 2]),
                        dir:     port_direction_control[g],
                        latch:   port_data_register[g],
                        pin:     pin_i[g],
                        rst_pin: rst_pin_mask[g]};
      prs_pin_cell u_cell (
        .cfg_i       (cfg[g]),
        .mode_i      (readback_mode_active_o),
        .chan_hit_i  (adc_chan == 3'(g)),
        .rd_bit_o    (port_rd[g]),
        .ana_close_o (ana_close[g])
      );
    end
  endgenerate

  // one access per request; ack high cycle keeps a held stb from repeating
  assign acc = req.cyc & req.stb & ~wb_ack_o & (state == PRS_IDLE);
  assign wr  = acc & req.we;
  assign rd  = acc & ~req.we;
  assign fall = pin_q & ~pin_i;
  assign bit_mask = 8'h01 << bitop_cmd[2:0];

  // register map, byte offsets, fields in the low bits:
  //   00 port data: write sets the latch, read gives the port read
  //   04 direction, 1 = input
  //   08 function select, two bits a pin
  //   0C unlock key
  //   10 wake-up enable per pin
  //   14 converter channel
  //   18 bit operation: [2:0] bit, [3] set, [4] direction
  //   1C status, cleared by a read
  //   20 interrupt mask
  //   24 reset-pin mask, such pins read 0 outside read-back mode
  //   unmapped offsets are answered, read 0 and ignore writes
  // a bit operation holds its answer until the byte is written back
  // status events in the cycle of a status read keep their bits

  // register file, bus answer and bit-operation sequencer
  always_comb begin
    next_state                  = state;
    next_port_data_register     = port_data_register;
    next_port_direction_control = port_direction_control;
    next_fsel                   = fsel;
    next_read_port_unlock       = read_port_unlock;
    next_wake_en                = wake_en;
    next_adc_chan               = adc_chan;
    next_rst_pin_mask           = rst_pin_mask;
    next_irq_mask               = irq_mask;
    next_bitop_cmd              = bitop_cmd;
    next_bitop_opnd             = bitop_opnd;
    next_wb_ack                 = 1'b0;
    next_wb_dat                 = 32'h0000_0000;
    bitop_done                  = 1'b0;
    // idle takes requests; read and write run a bit operation
    case (state)
      PRS_IDLE: begin
        if (wr && req.adr == prs_pkg::OFS_BITOP) begin
          // ack held back until the write-back is done; without the low byte lane it is given at once
          if (req.sel[0]) begin
            next_bitop_cmd = req.dat[4:0];
            next_state     = PRS_READ;
          end else begin
            next_wb_ack = 1'b1;
          end
        end else if (acc) begin
          next_wb_ack = 1'b1;
        end
        // plain register writes on the low byte lane
        if (wr && req.sel[0]) begin
          if (req.adr == prs_pkg::OFS_DATA) begin
            next_port_data_register = req.dat[7:0];
          end else if (req.adr == prs_pkg::OFS_DIR) begin
            next_port_direction_control = req.dat[7:0];
          end else if (req.adr == prs_pkg::OFS_FSEL) begin
            next_fsel[7:0] = req.dat[7:0];
          end else if (req.adr == prs_pkg::OFS_UNLOCK) begin
            next_read_port_unlock = req.dat[7:0];
          end else if (req.adr == prs_pkg::OFS_WAKE) begin
            next_wake_en = req.dat[7:0];
          end else if (req.adr == prs_pkg::OFS_CHAN) begin
            next_adc_chan = req.dat[2:0];
          end else if (req.adr == prs_pkg::OFS_MASK) begin
            next_irq_mask = req.dat[2:0];
          end else if (req.adr == prs_pkg::OFS_RSTPIN) begin
            next_rst_pin_mask = req.dat[7:0];
          end
        end
        // upper select byte rides on its own lane
        if (wr && req.sel[1] && req.adr == prs_pkg::OFS_FSEL) begin
          next_fsel[15:8] = req.dat[15:8];
        end
        // read multiplexer, zero for unmapped offsets
        if (rd) begin
          // data offset reads the port, as the core's port read does
          if (req.adr == prs_pkg::OFS_DATA) begin
            next_wb_dat[7:0] = port_rd;
          end else if (req.adr == prs_pkg::OFS_DIR) begin
            next_wb_dat[7:0] = port_direction_control;
          end else if (req.adr == prs_pkg::OFS_FSEL) begin
            next_wb_dat[15:0] = fsel;
          end else if (req.adr == prs_pkg::OFS_UNLOCK) begin
            next_wb_dat[7:0] = read_port_unlock;
          end else if (req.adr == prs_pkg::OFS_WAKE) begin
            next_wb_dat[7:0] = wake_en;
          end else if (req.adr == prs_pkg::OFS_CHAN) begin
            next_wb_dat[2:0] = adc_chan;
          end else if (req.adr == prs_pkg::OFS_BITOP) begin
            next_wb_dat[4:0] = bitop_cmd;
          end else if (req.adr == prs_pkg::OFS_STAT) begin
            next_wb_dat[2:0] = status;
          end else if (req.adr == prs_pkg::OFS_MASK) begin
            next_wb_dat[2:0] = irq_mask;
          end else if (req.adr == prs_pkg::OFS_RSTPIN) begin
            next_wb_dat[7:0] = rst_pin_mask;
          end
        end
      end
      PRS_READ: begin
        // whole port or direction byte is read first; on data, stray pin levels get written back
        if (bitop_cmd[prs_pkg::BITOP_DIR_POS]) begin
          next_bitop_opnd = port_direction_control;
        end else begin
          next_bitop_opnd = port_rd;
        end
        next_state = PRS_WRITE;
      end
      PRS_WRITE: begin
        // change the one bit, write the whole byte back and answer on the same edge
        if (bitop_cmd[prs_pkg::BITOP_SET_POS]) begin
          next_bitop_opnd = bitop_opnd | bit_mask;
        end else begin
          next_bitop_opnd = bitop_opnd & ~bit_mask;
        end
        if (bitop_cmd[prs_pkg::BITOP_DIR_POS]) begin
          next_port_direction_control = next_bitop_opnd;
        end else begin
          next_port_data_register = next_bitop_opnd;
        end
        bitop_done            = 1'b1;
        next_wb_ack           = 1'b1;
        next_state            = PRS_IDLE;
      end
      default: begin
        // unused encoding falls back to idle
        next_state = PRS_IDLE;
      end
    endcase
  end

  // derived pin, analog and mode levels
  always_comb begin
    next_mode = (next_read_port_unlock == prs_pkg::UNLOCK_KEY);
    // latch keeps its all-ones reset, so a new output drives high
    next_pin_oe = ~next_port_direction_control;
    for (int i = 0; i < 8; i++) begin
      if (next_rst_pin_mask[i]
          || next_fsel[2*i +: 2] == prs_pkg::PRS_FN_ANALOG) begin
        next_pin_oe[i] = 1'b0;
      end
    end
    next_ana_sw = ana_close;
  end

  // wake, sticky status and interrupt level
  always_comb begin
    next_wake = sleep_i & |(fall & wake_en);
    ev = 3'h0;
    ev[prs_pkg::ST_WAKE]  = next_wake;
    ev[prs_pkg::ST_MODE]  = next_mode & ~readback_mode_active_o;
    ev[prs_pkg::ST_BITOP] = bitop_done;
    // a read clears status, but an event in the same cycle wins
    next_status = status;
    if (rd && req.adr == prs_pkg::OFS_STAT) begin
      next_status = 3'h0;
    end
    next_status = next_status | ev;
    next_irq = |(next_status & next_irq_mask);
  end

  // state registers; reset values make every pin an input
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state                  <= PRS_IDLE;
      // configuration registers
      port_data_register     <= prs_pkg::RST_DATA;
      port_direction_control <= prs_pkg::RST_DIR;
      fsel                   <= prs_pkg::RST_FSEL;
      read_port_unlock       <= prs_pkg::RST_UNLOCK;
      wake_en                <= prs_pkg::RST_ZERO8;
      adc_chan               <= prs_pkg::RST_CHAN;
      rst_pin_mask           <= prs_pkg::RST_ZERO8;
      // status and bit-operation state
      status                 <= prs_pkg::RST_STAT;
      irq_mask               <= prs_pkg::RST_STAT;
      bitop_cmd              <= 5'h00;
      bitop_opnd             <= prs_pkg::RST_ZERO8;
      pin_q                  <= prs_pkg::RST_ZERO8;
      // bus answer and registered outputs
      wb_dat_o               <= 32'h0000_0000;
      wb_ack_o               <= 1'b0;
      pin_o                  <= prs_pkg::RST_DATA;
      pin_oe_o               <= prs_pkg::RST_ZERO8;
      ana_sw_o               <= prs_pkg::RST_ZERO8;
      readback_mode_active_o <= 1'b0;
      wake_o                 <= 1'b0;
      irq_o                  <= 1'b0;
    end else begin
      state                  <= next_state;
      // configuration registers
      port_data_register     <= next_port_data_register;
      port_direction_control <= next_port_direction_control;
      fsel                   <= next_fsel;
      read_port_unlock       <= next_read_port_unlock;
      wake_en                <= next_wake_en;
      adc_chan               <= next_adc_chan;
      rst_pin_mask           <= next_rst_pin_mask;
      // status and bit-operation state
      status                 <= next_status;
      irq_mask               <= next_irq_mask;
      bitop_cmd              <= next_bitop_cmd;
      bitop_opnd             <= next_bitop_opnd;
      pin_q                  <= pin_i; // previous level for falling edge
      // bus answer and registered outputs
      wb_dat_o               <= next_wb_dat;
      wb_ack_o               <= next_wb_ack;
      pin_o                  <= next_port_data_register;
      pin_oe_o               <= next_pin_oe;
      ana_sw_o               <= next_ana_sw;
      readback_mode_active_o <= next_mode;
      wake_o                 <= next_wake;
      irq_o                  <= next_irq;
    end
  end

endmodule : prs_port_readback

/* File: bench/prs_port_readback_assertions.sv */
// concurrent checks on the port read-back block ports
`timescale 1ns/10ps
module prs_port_readback_assertions (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [7:0]  pin_i,
  input wire logic [7:0]  pin_o,
  input wire logic [7:0]  pin_oe_o,
  input wire logic [7:0]  ana_sw_o,
  input wire logic        readback_mode_active_o,
  input wire logic        sleep_i,
  input wire logic        wake_o,
  input wire logic        irq_o
);
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // start of a bit op write versus any other access
  sequence s_bitop_req;
    $rose(wb_stb_i) && wb_cyc_i && wb_we_i && wb_sel_i[0] &&
      wb_adr_i == prs_pkg::OFS_BITOP;
  endsequence
  sequence s_plain_req;
    $rose(wb_stb_i) && wb_cyc_i && !(wb_we_i && wb_sel_i[0] &&
      wb_adr_i == prs_pkg::OFS_BITOP);
  endsequence
  sequence s_rmw_gap;
    !wb_ack_o [*2] ##1 wb_ack_o;
  endsequence
  // ack is a pulse, a held request must not be answered twice
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_plain_answer: assert property (s_plain_req |-> ##1 wb_ack_o)
    else $error("access not answered next cycle");
  chk_bitop_answer: assert property (
    s_bitop_req |-> ##1 s_rmw_gap) else $error("bit op answer timing");
  chk_dir_one_bit: assert property (
    wb_ack_o && wb_we_i && wb_adr_i == prs_pkg::OFS_BITOP && wb_dat_i[4]
    |-> $countones(pin_oe_o ^ $past(pin_oe_o)) <= 1)
    else $error("bit op touched more than one bit");
  chk_mode_key: assert property (
    wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == prs_pkg::OFS_UNLOCK
    |-> ##2 readback_mode_active_o ==
      ($past(wb_dat_i[7:0], 2) == prs_pkg::UNLOCK_KEY))
    else $error("mode does not follow key");
  chk_reset_state: assert property (
    $fell(rst_i) |-> !readback_mode_active_o && pin_o == 8'hFF &&
      pin_oe_o == 8'h00) else $error("bad state after reset");
  chk_readback_pin: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == prs_pkg::OFS_DATA &&
    readback_mode_active_o && $stable(readback_mode_active_o) &&
    $stable(pin_i) |-> wb_dat_o[7:0] == pin_i)
    else $error("read-back not pin level");
  chk_ana_closed: assert property (
    !readback_mode_active_o && $stable(readback_mode_active_o) &&
    $stable(ana_sw_o) && $stable(pin_oe_o)
    |-> (ana_sw_o & pin_oe_o) == 8'h00)
    else $error("analog path on a driven pin");
  chk_wake_cause: assert property (
    wake_o |-> $past(sleep_i) &&
      (|($past(pin_i, 2) & ~$past(pin_i)) ||
       |($past(pin_i, 3) & ~$past(pin_i, 2))))
    else $error("wake without falling edge");
endmodule : prs_port_readback_assertions

/* File: bench/prs_pin_model.sv */
// external pin model for port a
`timescale 1ns/10ps
module prs_pin_model (
  input  wire logic [7:0] drv_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] ext_i,
  output logic      [7:0] lvl_o
);
  // driven pins read their own level, released ones the outside world
  assign lvl_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule : prs_pin_model

/* File: bench/tb_prs_port_readback.sv */
// bus-level bench for the port read-back block
`timescale 1ns/10ps
module tb_prs_port_readback;
  logic        clk_i = 1'b0;
  logic        rst_i, cyc, stb, we, ack, mode, sleep, wake, irq;
  logic [7:0]  adr, pin, pin_o, pin_oe, ana_sw, ext, dr, lt, rm;
  logic [3:0]  sel;
  logic [15:0] fs;
  logic [31:0] dwr, drd, rdv;
  int          n_fail, checks_done, wakes;
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) if (wake === 1'b1) wakes++;
  prs_port_readback u_prs_port_readback (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dwr), .wb_dat_o(drd), .wb_ack_o(ack),
    .pin_i(pin), .pin_o(pin_o), .pin_oe_o(pin_oe), .ana_sw_o(ana_sw),
    .readback_mode_active_o(mode), .sleep_i(sleep), .wake_o(wake),
    .irq_o(irq));
  prs_pin_model u_prs_pin_model (.drv_i(pin_o), .oe_i(pin_oe),
    .ext_i(ext), .lvl_o(pin));
  task automatic wrap_up;
    if (n_fail == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t saw %h want %h", $time, s, e);
    end
  endtask : chk
  // one classic cycle, held until ack is sampled, bounded wait
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {cyc, stb, we, adr, dwr, sel} <= {2'b11, w, a, d, 4'hF};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdv = drd;
    {cyc, stb, we} <= 3'b000;
    if (ack !== 1'b1) begin
      n_fail++;
      wrap_up();
    end
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  // expected port read from configuration, pins and mode
  function automatic logic [7:0] exp_rd(input logic [15:0] f,
    input logic [7:0] d, input logic [7:0] l, input logic [7:0] x,
    input logic [7:0] r, input logic m);
    logic [7:0] v;
    logic [1:0] c;
    logic       p;
    for (int i = 0; i < 8; i++) begin
      c = f[2*i +: 2];
      p = (!d[i] && c != 2'h3 && !r[i]) ? l[i] : x[i];
      if (m) v[i] = p;
      else if (c == 2'h3 || r[i]) v[i] = 1'b0;
      else if (c == 2'h1) v[i] = d[i] ? 1'b0 : l[i];
      else v[i] = d[i] ? p : l[i];
    end
    return v;
  endfunction : exp_rd
  // main sequence; pins stay still around every port read
  initial begin
    {cyc, stb, we, adr, sel, dwr} = '0;
    {sleep, n_fail, checks_done, wakes} = '0;
    ext = 8'h5A;
    rst_i = 1'b1;
    tick(12);
    rst_i <= 1'b0;
    tick(1);
    chk(pin_o, 8'hFF);
    chk(pin_oe, 8'h00);
    rd(prs_pkg::OFS_DIR, 32'hFF);
    rd(prs_pkg::OFS_UNLOCK, 32'h0);
    rd(prs_pkg::OFS_DATA, 32'h5A);
    wr(prs_pkg::OFS_DIR, 32'h0);
    tick(2);
    chk(pin_o, 8'hFF);
    chk(pin_oe, 8'hFF);
    // every function code against three direction patterns
    fs = 16'hE4E4;
    lt = 8'h3C;
    wr(prs_pkg::OFS_DATA, {24'h0, lt});
    wr(prs_pkg::OFS_FSEL, {16'h0, fs});
    for (int k = 0; k < 3; k++) begin
      dr = (k == 0) ? 8'hF0 : (k == 1) ? 8'h0F : 8'hAA;
      rm = (k == 2) ? 8'h41 : 8'h00;
      wr(prs_pkg::OFS_DIR, {24'h0, dr});
      wr(prs_pkg::OFS_RSTPIN, {24'h0, rm});
      ext <= dr ^ 8'h66;
      tick(3);
      rd(prs_pkg::OFS_DATA, exp_rd(fs, dr, lt, ext, rm, 1'b0));
      chk(ana_sw, 8'h88);
    end
    wr(prs_pkg::OFS_MASK, 32'h5);
    wr(prs_pkg::OFS_CHAN, 32'h2);
    wr(prs_pkg::OFS_UNLOCK, 32'hCA);
    tick(2);
    chk(mode, 1'b1);
    rd(prs_pkg::OFS_DATA, exp_rd(fs, dr, lt, ext, rm, 1'b1));
    chk(ana_sw, 8'h8C);
    wr(prs_pkg::OFS_UNLOCK, 32'hCB);
    tick(2);
    chk(mode, 1'b0);
    chk(ana_sw, 8'h88);
    // bit ops on direction then data, status raises the interrupt
    wr(prs_pkg::OFS_BITOP, 32'h13);
    dr = dr & 8'hF7;
    rd(prs_pkg::OFS_DIR, {24'h0, dr});
    lt = exp_rd(fs, dr, lt, ext, rm, 1'b0) | 8'h02;
    wr(prs_pkg::OFS_BITOP, 32'h09);
    tick(2);
    chk(pin_o, lt);
    chk(irq, 1'b1);
    rd(prs_pkg::OFS_STAT, 32'h6);
    tick(2);
    chk(irq, 1'b0);
    wr(prs_pkg::OFS_UNLOCK, 32'hCA);
    tick(2);
    chk(irq, 1'b0);
    rd(prs_pkg::OFS_STAT, 32'h2);
    wr(8'h30, 32'hFFFFFFFF);
    rd(8'h30, 32'h0);
    // wake-up armed on pin 4 only
    wr(prs_pkg::OFS_UNLOCK, 32'h0);
    wr(prs_pkg::OFS_DIR, 32'hFF);
    wr(prs_pkg::OFS_FSEL, 32'h0);
    wr(prs_pkg::OFS_WAKE, 32'h10);
    ext <= 8'hFF;
    sleep <= 1'b1;
    tick(3);
    ext <= 8'hF7;
    tick(4);
    chk(wakes, 0);
    ext <= 8'hE7;
    tick(4);
    chk(wakes, 1);
    chk(irq, 1'b1);
    rd(prs_pkg::OFS_STAT, 32'h1);
    tick(2);
    chk(irq, 1'b0);
    wrap_up();
  end
endmodule : tb_prs_port_readback
bind prs_port_readback prs_port_readback_assertions
  u_prs_port_readback_assertions (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .pin_i, .pin_o, .pin_oe_o, .ana_sw_o, .readback_mode_active_o,
  .sleep_i, .wake_o, .irq_o);
